// >>> logic/eidm_pkg.sv
// Package with offsets, field positions and reset values of the encoder index and deviation monitor.
package eidm_pkg;
    // Register offsets as seen on the register port.
    localparam logic [7:0]  EIDM_STATUS_OFS    = 8'h31;
    localparam logic [7:0]  EIDM_LATCH_OFS     = 8'h32;
    localparam logic [7:0]  EIDM_DEVLIMIT_OFS  = 8'h33;
    localparam logic [7:0]  EIDM_VSTOPL_OFS    = 8'h34;
    // Status register field positions.
    localparam int          EIDM_IDX_BIT       = 0;
    localparam int          EIDM_WARN_BIT      = 1;
    // Width of the deviation limit field.
    localparam int          EIDM_LIMIT_W       = 20;
    // Values after reset.
    localparam logic [31:0] EIDM_LATCH_RST     = 32'h0000_0000;
    localparam logic [19:0] EIDM_LIMIT_RST     = 20'h0_0000;
    localparam logic [31:0] EIDM_VSTOPL_RST    = 32'h0000_0000;
    localparam logic        EIDM_FLAG_RST      = 1'b0;
endpackage

// >>> logic/eidm_cmp_if.sv
// Interface carrying positions, limit and verdict between the monitor and its deviation comparator.
`timescale 1ns/1ps
interface eidm_cmp_if;
    logic [31:0] encPos;    // Encoder count chosen for the check.
    logic [31:0] motorPos;  // Internal motor position.
    logic [19:0] limit;     // Deviation limit, zero turns the check off.
    logic        exceeded;  // Registered verdict of the comparator.
    modport src (output encPos, output motorPos, output limit, input exceeded);
    modport cmp (input encPos, input motorPos, input limit, output exceeded);
endinterface

// >>> logic/eidm_dev_cmp.sv
// Deviation comparator: absolute difference of encoder and motor position against the limit.
`timescale 1ns/1ps
module eidm_dev_cmp
    import eidm_pkg::*;
(
    input  wire logic sys_clk,
    input  wire logic rst_n,
    input  wire logic clkEn,
    eidm_cmp_if.cmp   cmpBus
);
    logic signed [32:0] diffSigned;  // Signed difference, one bit wider so it cannot wrap.
    logic        [32:0] diffAbs;     // Magnitude of the difference.
    logic               exceeded_q;  // Verdict, registered.
    logic               exceeded_d;

    // Sign-extend both positions before subtracting; a plain 32-bit subtract would wrap near the ends.
    always_comb begin
        diffSigned = {cmpBus.encPos[31], cmpBus.encPos} - {cmpBus.motorPos[31], cmpBus.motorPos};
        diffAbs    = diffSigned[32] ? 33'(-diffSigned) : 33'(diffSigned); // R9
        exceeded_d = (cmpBus.limit != EIDM_LIMIT_RST) && (diffAbs > {13'h0, cmpBus.limit}); // R5 R6
    end

    // The verdict is refreshed every enabled cycle, so every position update is seen.
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            exceeded_q <= 1'b0;
        end else if (clkEn) begin
            exceeded_q <= exceeded_d; // R9
        end
    end

    assign cmpBus.exceeded = exceeded_q;

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);

    chk_zero_limit_off: assert property (clkEn && cmpBus.limit == 20'h0_0000 |=> !exceeded_q) // R6
        else $error("Deviation verdict raised with a zero limit.");
    chk_abs_compare: assert property (clkEn && cmpBus.limit != 20'h0_0000 && cmpBus.encPos == cmpBus.motorPos // R9
        |=> !exceeded_q)
        else $error("Equal positions judged as deviating.");
endmodule

// >>> logic/eidm_monitor.sv
// Top of the encoder index and deviation monitor with its register port.
// Operation
// (R1) Index event sets status bit 0, write-one clears.
// (R2) Deviation warning in status bit 1, write-one clears.
// (R3) Clear ignored while deviation still exists.
// (R4) Index event latches encoder position until next.
// (R5) Warn when deviation exceeds 20-bit limit.
// (R6) Zero limit disables deviation checking entirely.
// (R7) Latch, limit and both flags reset to zero.
// (R8) Left stop when position at or below limit.
// (R9) Absolute signed difference, re-evaluated every update.
`timescale 1ns/1ps
module eidm_monitor
    import eidm_pkg::*;
(
    input  wire logic        sys_clk,
    input  wire logic        rst_n,
    input  wire logic        clkEn,
    input  wire logic [31:0] encPos,
    input  wire logic [31:0] bemfEncPos,
    input  wire logic [31:0] motorPos,
    input  wire logic        useBemfEnc,
    input  wire logic        stopUsesEnc,
    input  wire logic        indexEvent,
    input  wire logic [7:0]  regAddr,
    input  wire logic        regWrEn,
    input  wire logic [31:0] regWrData,
    input  wire logic        regRdEn,
    output logic      [31:0] regRdData,
    output logic             indexFlag,
    output logic             devWarn,
    output logic             leftStop
);
    // State and helper signals of the monitor; every output of the block is one of the flip-flops among them.
    logic [31:0] latch_q;      // Encoder position caught at the last index event.
    logic [19:0] devLimit_q;   // Deviation limit, zero means off.
    logic [31:0] vstopL_q;     // Signed left soft stop limit.
    logic        idxFlag_q;    // Sticky index event flag.
    logic        warn_q;       // Sticky deviation warning flag.
    logic        leftStop_q;   // Registered left stop verdict.
    logic [31:0] rdData_q;     // Read data, valid the cycle after the read strobe.
    logic        stsWrite;     // Write to the status register this cycle.
    logic        cmpExceeded;  // Comparator verdict.
    logic [31:0] stopPos;      // Position chosen for the soft stop compare.

    // The comparator lives in its own module; positions and limit reach it over one interface.
    eidm_cmp_if cmpBus();

    // The comparator sees either the quadrature count or the back-EMF derived count.
    // Only the encoder side has a choice; the motor position always comes straight in.
    assign cmpBus.encPos   = useBemfEnc ? bemfEncPos : encPos; // R5
    assign cmpBus.motorPos = motorPos;
    assign cmpBus.limit    = devLimit_q;
    assign cmpExceeded     = cmpBus.exceeded;

    // The comparator shares enable and reset, so its verdict freezes with the rest.
    // Its verdict is registered, which adds one cycle between a position step and the warning.
    eidm_dev_cmp u_cmp (
        .sys_clk (sys_clk),
        .rst_n   (rst_n),
        .clkEn   (clkEn),
        .cmpBus  (cmpBus.cmp)
    );

    // Decoding of a write to one offset, used for every writable register.
    // The checks below use it too, so logic and checks decode the address the same way.
    function automatic logic wrHit(input logic [7:0] addr, input logic we, input logic [7:0] ofs);
        return we && (addr == ofs);
    endfunction

    // One status write serves both write-one-to-clear flags.
    assign stsWrite = wrHit(regAddr, regWrEn, EIDM_STATUS_OFS);

    // Index latch: written only by hardware, so software writes to its offset are dropped.
    // A refused write raises no error; the latch offset simply reads back what was caught.
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            // Reset clears the latch like every other register.
            latch_q <= EIDM_LATCH_RST; // R7
        end else if (clkEn && indexEvent) begin
            // The quadrature count is latched, never the back-EMF estimate.
            latch_q <= encPos; // R4
        end
    end

    // Writable configuration registers.
    // A write lands one edge after its strobe and is frozen with the enable.
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            devLimit_q <= EIDM_LIMIT_RST; // R7
            vstopL_q   <= EIDM_VSTOPL_RST;
        end else if (clkEn) begin
            if (wrHit(regAddr, regWrEn, EIDM_DEVLIMIT_OFS)) begin
                // Upper limit bits are dropped and read back as zero.
                devLimit_q <= regWrData[EIDM_LIMIT_W-1:0]; // R5
            end
            // The left stop limit is a full signed word.
            if (wrHit(regAddr, regWrEn, EIDM_VSTOPL_OFS)) begin
                vstopL_q <= regWrData;
            end
        end
    end

    // Index flag: a new event in the clearing cycle wins, so no event is lost.
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            idxFlag_q <= EIDM_FLAG_RST; // R7
        end else if (clkEn) begin
            // Set has priority over a clear in the same cycle.
            if (indexEvent) begin
                idxFlag_q <= 1'b1; // R1
            end else if (stsWrite && regWrData[EIDM_IDX_BIT]) begin
                // Only a one in bit 0 clears; a zero leaves the flag alone.
                idxFlag_q <= 1'b0; // R1
            end
        end
    end

    // Deviation warning: the clear only takes once the condition has gone.
    // Limitation: the verdict lags the positions by one cycle, so a clear in the cycle right
    // after the deviation ends can still be refused; software should simply retry it.
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            warn_q <= EIDM_FLAG_RST; // R7
        end else if (clkEn) begin
            // A live verdict keeps the flag up, so a clear against it is lost.
            if (cmpExceeded) begin
                warn_q <= 1'b1; // R2 R3
            end else if (stsWrite && regWrData[EIDM_WARN_BIT]) begin
                // Only a verdict that has dropped lets the write-one clear through.
                warn_q <= 1'b0; // R2
            end
        end
    end

    // Left soft stop: signed compare against the chosen position.
    // The compare is signed, so a negative limit works across the middle of the count range.
    assign stopPos = stopUsesEnc ? encPos : motorPos;
    // The verdict is valid from the first enabled edge after reset.
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            leftStop_q <= 1'b0;
        end else if (clkEn) begin
            leftStop_q <= ($signed(stopPos) <= $signed(vstopL_q)); // R8
        end
    end

    // Read path: registered, unmapped offsets and reserved bits read as zero.
    // A read in the same cycle as a write returns the value from before the write.
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            rdData_q <= 32'h0000_0000;
        end else if (clkEn && regRdEn) begin
            // Status bits 31:2 and limit bits 31:20 are reserved and read as zero.
            // Any other offset falls to the default and reads zero rather than a stale word.
            unique case (regAddr)
                EIDM_STATUS_OFS:   rdData_q <= {30'h0, warn_q, idxFlag_q};
                EIDM_LATCH_OFS:    rdData_q <= latch_q;
                EIDM_DEVLIMIT_OFS: rdData_q <= {12'h000, devLimit_q};
                EIDM_VSTOPL_OFS:   rdData_q <= vstopL_q;
                default:           rdData_q <= 32'h0000_0000;
            endcase
        end
    end

    // Outputs come straight from the flip-flops above, so the pins never see logic glitches.
    assign regRdData = rdData_q;
    assign indexFlag = idxFlag_q;
    assign devWarn   = warn_q;
    assign leftStop  = leftStop_q;

    // Checks run on the system clock and rest while reset is low, except chk_reset_zero, which runs through reset.
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);

    // Index flag and latch.
    chk_index_sets_flag: assert property (clkEn && indexEvent |=> idxFlag_q) // R1
        else $error("Index event did not set the flag.");
    chk_index_w1c: assert property (clkEn && stsWrite && regWrData[0] && !indexEvent |=> !idxFlag_q) // R1
        else $error("Index flag not cleared by write one.");
    chk_index_needs_event: assert property (clkEn && !idxFlag_q && !indexEvent |=> !idxFlag_q) // R1
        else $error("Index flag rose without an index event.");
    chk_latch_capture: assert property (clkEn && indexEvent |=> latch_q == $past(encPos)) // R4
        else $error("Latch does not hold position at index event.");
    chk_latch_holds: assert property (!(clkEn && indexEvent) |=> $stable(latch_q)) // R4
        else $error("Latch changed without an index event.");

    // Deviation warning.
    chk_warn_sets: assert property (clkEn && cmpExceeded |=> warn_q) // R2
        else $error("Deviation did not raise the warning.");
    chk_warn_needs_cause: assert property (clkEn && !warn_q && !cmpExceeded |=> !warn_q) // R2
        else $error("Deviation warning rose without a deviation.");
    chk_warn_clear_blocked: assert property (clkEn && cmpExceeded && stsWrite && regWrData[1] |=> warn_q) // R3
        else $error("Warning cleared while deviation persists.");
    chk_warn_clear_ok: assert property (clkEn && !cmpExceeded && stsWrite && regWrData[1] |=> !warn_q) // R2
        else $error("Warning not cleared after deviation ended.");
    chk_zero_disables: assert property (clkEn && devLimit_q == 20'h0_0000 ##1 clkEn && !warn_q |=> !warn_q) // R6
        else $error("Zero limit still raised the warning.");

    // Registers, read path and soft stop.
    chk_limit_write: assert property (clkEn && wrHit(regAddr, regWrEn, EIDM_DEVLIMIT_OFS) // R5
        |=> {12'h000, devLimit_q} == ($past(regWrData) & 32'h000f_ffff))
        else $error("Deviation limit write lost.");
    chk_limit_read: assert property (clkEn && regRdEn && regAddr == EIDM_DEVLIMIT_OFS // R5
        |=> regRdData == {12'h000, $past(devLimit_q)})
        else $error("Deviation limit read back wrong.");
    chk_status_read: assert property (clkEn && regRdEn && regAddr == EIDM_STATUS_OFS // R1 R2
        |=> regRdData == {30'h0, $past(warn_q), $past(idxFlag_q)})
        else $error("Status read does not show both flags.");
    chk_left_stop: assert property (clkEn |=> leftStop_q == ($signed($past(stopPos)) <= $signed($past(vstopL_q)))) // R8
        else $error("Left stop verdict wrong.");
    chk_enable_freeze: assert property (!clkEn // R1 R2 R4
        |=> $stable(latch_q) && $stable(idxFlag_q) && $stable(warn_q) && $stable(devLimit_q))
        else $error("State moved while the enable was low.");
    chk_reset_zero: assert property (disable iff (1'b0) !rst_n // R7
        |=> latch_q == 32'h0 && devLimit_q == 20'h0 && !idxFlag_q && !warn_q)
        else $error("Registers not zero after reset.");

    // Scenarios worth seeing in coverage.
    cov_index_event: cover property (clkEn && indexEvent ##1 idxFlag_q);
    cov_warn_raised: cover property (clkEn && cmpExceeded ##1 warn_q);
    cov_clear_refused: cover property (clkEn && cmpExceeded && stsWrite && regWrData[1]);
    cov_left_stop: cover property (leftStop_q);
    cov_limit_zeroed: cover property (clkEn && warn_q && devLimit_q == 20'h0_0000);
endmodule

// >>> bench/eidm_enc_model.sv
// Encoder stand-in that supplies the encoder count, a back-EMF count and the index pulse.
`timescale 1ns/1ps
module eidm_enc_model #(
    parameter logic [31:0] BEMF_LAG = 32'h0000_0007  // Plain default lag of the back-EMF estimate.
) (
    input  wire logic [31:0] loadVal,
    input  wire logic        idxReq,
    output logic      [31:0] encPos,
    output logic      [31:0] bemfEncPos,
    output logic             indexEvent
);
    // Counts follow the request at once, so they only move when the bench drives, at the falling edge.
    assign encPos     = loadVal;
    // The back-EMF estimate trails the encoder, so a wrong select shows as a different deviation.
    assign bemfEncPos = loadVal - BEMF_LAG;
    // One index pulse for every cycle that the bench requests one.
    assign indexEvent = idxReq;
endmodule

// >>> bench/tb.sv
// Self-checking bench for the encoder index and deviation monitor.
`timescale 1ns/1ps
module tb;
    import eidm_pkg::*;
    logic        sys_clk = 1'b0, rst_n = 1'b0, clkEn = 1'b1, regWrEn = 1'b0, regRdEn = 1'b0;
    logic        idxReq = 1'b0, useBemfEnc = 1'b0, stopUsesEnc = 1'b0, rdSeen = 1'b0;
    logic        indexFlag, devWarn, leftStop;
    logic [7:0]  regAddr = 8'h00;
    logic [31:0] regWrData = 32'h0, motorPos = 32'h0, loadVal = 32'h0, encPos, bemfEncPos, regRdData;
    logic [31:0] lim, latched;
    logic signed [31:0] d;
    logic        indexEvent, expWarn;
    logic [31:0] expQ[$];                 // Expected read data, oldest first.
    logic [7:0]  ofs[5] = '{EIDM_STATUS_OFS, EIDM_LATCH_OFS, EIDM_DEVLIMIT_OFS, EIDM_VSTOPL_OFS, 8'h40};
    int          bad_count = 0, checks = 0, cycles = 0, seed;

    eidm_enc_model u_eidm_enc_model (.loadVal(loadVal), .idxReq(idxReq), .encPos(encPos),
        .bemfEncPos(bemfEncPos), .indexEvent(indexEvent));
    eidm_monitor u_eidm_monitor (.sys_clk(sys_clk), .rst_n(rst_n), .clkEn(clkEn), .encPos(encPos),
        .bemfEncPos(bemfEncPos), .motorPos(motorPos), .useBemfEnc(useBemfEnc), .stopUsesEnc(stopUsesEnc),
        .indexEvent(indexEvent), .regAddr(regAddr), .regWrEn(regWrEn), .regWrData(regWrData),
        .regRdEn(regRdEn), .regRdData(regRdData), .indexFlag(indexFlag), .devWarn(devWarn),
        .leftStop(leftStop));

    // Free-running 100 MHz clock.
    always #5 sys_clk = ~sys_clk;

    // Hang guard: the sequence needs under two hundred cycles, so a far larger count means a stall.
    always @(posedge sys_clk) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            bad_count++;
            test_done();
        end
    end

    // A read taken at a rising edge shows its data after that edge; compare it at the next falling edge.
    always @(posedge sys_clk) rdSeen <= regRdEn && clkEn && rst_n;
    always @(negedge sys_clk) begin
        if (rdSeen) begin
            cmp(regRdData, expQ.pop_front());
        end
    end

    // One comparison, counted, with a line on mismatch.
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            bad_count++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // Register write strobe held for exactly one enabled edge.
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        @(negedge sys_clk);
        regAddr = a;
        regWrData = v;
        regWrEn = 1'b1;
        @(negedge sys_clk);
        regWrEn = 1'b0;
    endtask

    // Register read strobe; the expected word goes to the queue for the watcher.
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        @(negedge sys_clk);
        regAddr = a;
        regRdEn = 1'b1;
        expQ.push_back(e);
        @(negedge sys_clk);
        regRdEn = 1'b0;
    endtask

    // Prints the counts and the verdict, then ends the run.
    task automatic test_done;
        $display("checks=%0d bad_count=%0d", checks, bad_count);
        if (bad_count == 0 && checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    // Main sequence: reset, register map, index capture, deviation and left stop.
    initial begin
        seed = 26;
        repeat (10) @(negedge sys_clk);
        rst_n = 1'b1;
        foreach (ofs[i]) rd(ofs[i], 32'h0);
        // Index event with a random count; the count moves on afterwards and the latch must hold.
        @(negedge sys_clk);
        loadVal = $random(seed);
        latched = loadVal;
        idxReq = 1'b1;
        @(negedge sys_clk);
        idxReq = 1'b0;
        loadVal = ~loadVal;
        cmp({31'h0, indexFlag}, 32'h1);
        rd(EIDM_LATCH_OFS, latched);
        wr(EIDM_LATCH_OFS, 32'h1234_5678);
        rd(EIDM_LATCH_OFS, latched);
        rd(EIDM_STATUS_OFS, 32'h1);
        wr(EIDM_STATUS_OFS, 32'h1);
        cmp({31'h0, indexFlag}, 32'h0);
        wr(EIDM_DEVLIMIT_OFS, 32'hfff0_0005);
        rd(EIDM_DEVLIMIT_OFS, 32'h0000_0005);
        // Random deviations around the limit of 5, both signs, both count sources.
        for (int i = 0; i < 8; i++) begin
            @(negedge sys_clk);
            useBemfEnc = i[0];
            motorPos = $random(seed);
            // The first two steps sit right at the limit and one step past it.
            d = (i < 2) ? (i[0] ? -6 : 5) : $random(seed) % 12;
            loadVal = motorPos + d + (i[0] ? 32'h7 : 32'h0);
            expWarn = (d > 5) || (d < -5);
            @(negedge sys_clk);
            wr(EIDM_STATUS_OFS, 32'h2);
            cmp({31'h0, devWarn}, {31'h0, expWarn});
            @(negedge sys_clk);
            loadVal = motorPos + (i[0] ? 32'h7 : 32'h0);
            repeat (2) @(negedge sys_clk);
            wr(EIDM_STATUS_OFS, 32'h2);
            cmp({31'h0, devWarn}, 32'h0);
        end
        // A persisting warning clears on a write-one once a zero limit drops the verdict, after which no deviation warns.
        @(negedge sys_clk);
        loadVal = motorPos ^ 32'h8000_0000;
        repeat (3) @(negedge sys_clk);
        rd(EIDM_STATUS_OFS, 32'h2);
        wr(EIDM_DEVLIMIT_OFS, 32'h0);
        repeat (2) @(negedge sys_clk);
        wr(EIDM_STATUS_OFS, 32'h2);
        repeat (3) @(negedge sys_clk);
        cmp({31'h0, devWarn}, 32'h0);
        // Signed left stop with both sources and the equal boundary.
        lim = $random(seed);
        wr(EIDM_VSTOPL_OFS, lim);
        rd(EIDM_VSTOPL_OFS, lim);
        for (int i = 0; i < 8; i++) begin
            @(negedge sys_clk);
            stopUsesEnc = i[0];
            loadVal = i[1] ? lim : $random(seed);
            motorPos = i[2] ? lim : $random(seed);
            @(negedge sys_clk);
            cmp({31'h0, leftStop}, {31'h0, $signed(i[0] ? loadVal : motorPos) <= $signed(lim)});
        end
        // Enable low: an index event and a register write must both be ignored.
        @(negedge sys_clk);
        clkEn = 1'b0;
        idxReq = 1'b1;
        loadVal = ~latched;
        regAddr = EIDM_VSTOPL_OFS;
        regWrData = ~lim;
        regWrEn = 1'b1;
        repeat (2) @(negedge sys_clk);
        clkEn = 1'b1;
        idxReq = 1'b0;
        regWrEn = 1'b0;
        cmp({31'h0, indexFlag}, 32'h0);
        rd(EIDM_LATCH_OFS, latched);
        rd(EIDM_VSTOPL_OFS, lim);
        // A live index event, then a reset in mid-run that must clear every register again.
        @(negedge sys_clk);
        idxReq = 1'b1;
        @(negedge sys_clk);
        idxReq = 1'b0;
        cmp({31'h0, indexFlag}, 32'h1);
        rd(EIDM_LATCH_OFS, ~latched);
        wr(EIDM_DEVLIMIT_OFS, 32'h0000_0003);
        rst_n = 1'b0;
        repeat (2) @(negedge sys_clk);
        rst_n = 1'b1;
        foreach (ofs[i]) rd(ofs[i], 32'h0);
        repeat (2) @(negedge sys_clk);
        test_done();
    end
endmodule
